// ### design/fltc_regs.svh
`ifndef FLTC_REGS_SVH
`define FLTC_REGS_SVH
// ------------------------------------------------------------
// query table layout
// ------------------------------------------------------------
`define FLTC_PARAM_ID   8'h9A
`define FLTC_PARAM_LEN  8'h2A
`define FLTC_NUM_ROWS   8'h05
`define FLTC_ROW_LEN    8'h08
`define FLTC_OFS_ID     6'h00
`define FLTC_OFS_LEN    6'h01
`define FLTC_OFS_ROWS   6'h02
`define FLTC_OFS_RLEN   6'h03
`define FLTC_OFS_HDR    6'h04
`define FLTC_OFS_LAST   6'h2B
`define FLTC_ROW_HDR    64'h4643_0D0E_BDBE_EDEE
`define FLTC_ROW_LC3    64'h3203_0401_0202_0103
`define FLTC_ROW_LC0    64'h4200_0402_0204_0106
`define FLTC_ROW_LC1    64'h4201_0404_0205_0107
`define FLTC_ROW_LC2    64'h4202_0405_0206_0108
`define FLTC_FILL       8'hFF
// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define FLTC_OP_FAST3   8'h0D
`define FLTC_OP_FAST4   8'h0E
`define FLTC_OP_DUAL3   8'hBD
`define FLTC_OP_DUAL4   8'hBE
`define FLTC_OP_QUAD3   8'hED
`define FLTC_OP_QUAD4   8'hEE
`define FLTC_OP_QUERY   8'hA7
`define FLTC_QRY_MODE   8'h00
`define FLTC_QRY_DUMMY  8'h01
// ------------------------------------------------------------
// link framing and timing
// ------------------------------------------------------------
`define FLTC_OPC_LAST   8'h07
`define FLTC_ABITS3     8'h18
`define FLTC_ABITS4     8'h20
`define FLTC_BYTE_BITS  4'h8
`define FLTC_MODE_BITS  8'h00
`define FLTC_CLK_MHZ    8'h14
`define FLTC_SCK_DIV    8'h02
`define FLTC_SCK_MHZ    (`FLTC_CLK_MHZ / `FLTC_SCK_DIV)
`endif

// ### design/fltc_pkg.sv
package fltc_pkg;
`include "fltc_regs.svh"

   typedef enum logic [1:0] {FLTC_FAST, FLTC_DUAL, FLTC_QUAD, FLTC_QUERY} fltc_kind_t;

   // ---------------------------------------------------------
   // table access
   // ---------------------------------------------------------
   function automatic logic [63:0] fltc_row(input logic [2:0] r);
      case (r)
         3'h0:    fltc_row = `FLTC_ROW_HDR;
         3'h1:    fltc_row = `FLTC_ROW_LC3;
         3'h2:    fltc_row = `FLTC_ROW_LC0;
         3'h3:    fltc_row = `FLTC_ROW_LC1;
         3'h4:    fltc_row = `FLTC_ROW_LC2;
         default: fltc_row = {8{`FLTC_FILL}};
      endcase
   endfunction

   function automatic logic [7:0] fltc_pick(input logic [63:0] row, input logic [2:0] col);
      fltc_pick = 8'(row >> {3'h7 - col, 3'h0});
   endfunction

   function automatic logic [7:0] fltc_tbl_byte(input logic [5:0] off);
      logic [5:0] rel;
      rel = off - `FLTC_OFS_HDR;
      case (off)
         `FLTC_OFS_ID:   fltc_tbl_byte = `FLTC_PARAM_ID;
         `FLTC_OFS_LEN:  fltc_tbl_byte = `FLTC_PARAM_LEN;
         `FLTC_OFS_ROWS: fltc_tbl_byte = `FLTC_NUM_ROWS;
         `FLTC_OFS_RLEN: fltc_tbl_byte = `FLTC_ROW_LEN;
         default: begin
            if (off > `FLTC_OFS_LAST) fltc_tbl_byte = `FLTC_FILL;
            else fltc_tbl_byte = fltc_pick(fltc_row(rel[5:3]), rel[2:0]);
         end
      endcase
   endfunction

   // row 1..4 holds codes 11b, 00b, 01b, 10b
   function automatic logic [63:0] fltc_code_row(input logic [1:0] code);
      fltc_code_row = fltc_row({1'b0, code + 2'h1} + 3'h1);
   endfunction

   function automatic logic [7:0] fltc_ceiling(input logic [1:0] code);
      fltc_ceiling = fltc_pick(fltc_code_row(code), 3'h0);
   endfunction

   // sel 0 gives mode cycles, sel 1 dummy cycles
   function automatic logic [7:0] fltc_lat(input logic [1:0] code, input fltc_kind_t k,
                                           input logic sel);
      if (k == FLTC_QUERY) fltc_lat = sel ? `FLTC_QRY_DUMMY : `FLTC_QRY_MODE;
      else fltc_lat = fltc_pick(fltc_code_row(code), {k[1:0], sel} + 3'h2);
   endfunction

   // ---------------------------------------------------------
   // opcodes and lanes
   // ---------------------------------------------------------
   function automatic logic [7:0] fltc_opcode(input fltc_kind_t k, input logic a4);
      case (k)
         FLTC_FAST: fltc_opcode = a4 ? `FLTC_OP_FAST4 : `FLTC_OP_FAST3;
         FLTC_DUAL: fltc_opcode = a4 ? `FLTC_OP_DUAL4 : `FLTC_OP_DUAL3;
         FLTC_QUAD: fltc_opcode = a4 ? `FLTC_OP_QUAD4 : `FLTC_OP_QUAD3;
         default:   fltc_opcode = `FLTC_OP_QUERY;
      endcase
   endfunction

   // bits per serial clock: two edges times the lane count
   function automatic logic [3:0] fltc_bpc(input fltc_kind_t k);
      case (k)
         FLTC_DUAL: fltc_bpc = 4'h4;
         FLTC_QUAD: fltc_bpc = 4'h8;
         default:   fltc_bpc = 4'h2;
      endcase
   endfunction

   function automatic logic [7:0] fltc_mask(input logic [3:0] bpc);
      fltc_mask = 8'((9'h001 << bpc) - 9'h001);
   endfunction
endpackage

// ### design/fltc_link_if.sv
`timescale 1ns/1ps
`include "fltc_regs.svh"
interface fltc_link_if;
   logic       cs_n;
   logic       sck_en;
   logic [7:0] h_dq_o;
   logic       h_dq_oe_n;
   logic [7:0] d_dq_o;
   logic       d_dq_oe_n;
   logic [7:0] dq;

   // resolved data lanes, pulled high when nobody drives
   assign dq = !h_dq_oe_n ? h_dq_o : (!d_dq_oe_n ? d_dq_o : `FLTC_FILL);

   modport host (output cs_n, sck_en, h_dq_o, h_dq_oe_n, input dq);
   modport dev  (input cs_n, sck_en, dq, output d_dq_o, d_dq_oe_n);
endinterface

// ### design/fltc_flash_end.sv
`timescale 1ns/1ps
`include "fltc_regs.svh"
module fltc_flash_end
   import fltc_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // link to the controller
   fltc_link_if.dev         lk,
   // latency code in force
   input  wire logic [1:0]  i_latency_code,
   // array read port
   output logic      [31:0] o_rd_addr,
   input  wire logic [7:0]  i_rd_byte,
   output logic             o_read_active
);
   typedef enum {D_OPC, D_ADDR, D_MODE, D_DUMMY, D_DATA, D_SKIP} fltc_dst_t;

   fltc_dst_t   state_q, state_d;
   logic [7:0]  cnt_q, cnt_d;
   logic [7:0]  op_q, op_d;
   logic [31:0] addr_q, addr_d;
   logic [7:0]  tx_q, tx_d;
   logic [3:0]  bcnt_q, bcnt_d;
   logic [7:0]  dout_q, dout_d;
   logic        oe_n_q, oe_n_d;
   fltc_kind_t  kind_q, kind_d;
   logic        a4_q, a4_d;
   logic [7:0]  mode_q, mode_d;
   logic [7:0]  dummy_q, dummy_d;
   logic        beat;
   logic [3:0]  bpc;
   logic [7:0]  abits;
   logic [7:0]  src;
   logic [7:0]  op_full;

   // ---------------------------------------------------------
   // beat qualify and data source
   // ---------------------------------------------------------
   assign beat    = lk.sck_en & ~lk.cs_n;
   assign bpc     = fltc_bpc(kind_q);
   assign abits   = a4_q ? `FLTC_ABITS4 : `FLTC_ABITS3;
   assign op_full = {op_q[6:0], lk.dq[0]};
   // query reads serve the table, the rest the array
   assign src = (kind_q == FLTC_QUERY) ? fltc_tbl_byte(addr_q[5:0]) : i_rd_byte;

   // ---------------------------------------------------------
   // opcode decode
   // ---------------------------------------------------------
   always_comb begin
      kind_d = kind_q;
      a4_d   = a4_q;
      case (op_full)
         `FLTC_OP_FAST3, `FLTC_OP_FAST4: kind_d = FLTC_FAST;
         `FLTC_OP_DUAL3, `FLTC_OP_DUAL4: kind_d = FLTC_DUAL;
         `FLTC_OP_QUAD3, `FLTC_OP_QUAD4: kind_d = FLTC_QUAD;
         default:                        kind_d = FLTC_QUERY;
      endcase
      a4_d = (op_full == `FLTC_OP_FAST4) || (op_full == `FLTC_OP_DUAL4) ||
             (op_full == `FLTC_OP_QUAD4);
   end

   // ---------------------------------------------------------
   // frame sequencing on each serial beat
   // ---------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      op_d    = op_q;
      addr_d  = addr_q;
      tx_d    = tx_q;
      bcnt_d  = bcnt_q;
      dout_d  = dout_q;
      oe_n_d  = oe_n_q;
      mode_d  = mode_q;
      dummy_d = dummy_q;
      if (lk.cs_n) begin
         state_d = D_OPC;
         cnt_d   = 8'h00;
         oe_n_d  = 1'b1;
      end else if (beat) begin
         case (state_q)
            D_OPC: begin
               op_d  = op_full;
               cnt_d = cnt_q + 8'h01;
               if (cnt_q == `FLTC_OPC_LAST) begin
                  cnt_d = 8'h00;
                  if (fltc_opcode(kind_d, a4_d) == op_full) begin
                     state_d = D_ADDR;
                     addr_d  = 32'h0000_0000;
                     // latency counts follow the code in force
                     mode_d  = fltc_lat(i_latency_code, kind_d, 1'b0);
                     dummy_d = fltc_lat(i_latency_code, kind_d, 1'b1);
                  end else begin
                     state_d = D_SKIP;
                  end
               end
            end
            D_ADDR: begin
               addr_d = (addr_q << bpc) | {24'h00_0000, lk.dq & fltc_mask(bpc)};
               cnt_d  = cnt_q + {4'h0, bpc};
               if (cnt_q + {4'h0, bpc} == abits) begin
                  cnt_d   = 8'h00;
                  state_d = (mode_q != 8'h00) ? D_MODE : D_DUMMY;
               end
            end
            D_MODE: begin
               // mode bits follow the address, host drives them
               cnt_d = cnt_q + 8'h01;
               if (cnt_q + 8'h01 == mode_q) begin
                  cnt_d   = 8'h00;
                  state_d = D_DUMMY;
               end
            end
            D_DUMMY: begin
               cnt_d = cnt_q + 8'h01;
               if (cnt_q + 8'h01 == dummy_q) begin
                  // first data bits stand for the next beat
                  state_d = D_DATA;
                  dout_d  = 8'(src >> (`FLTC_BYTE_BITS - bpc));
                  tx_d    = 8'(src << bpc);
                  bcnt_d  = bpc;
                  addr_d  = addr_q + 32'h0000_0001;
                  oe_n_d  = 1'b0;
               end
            end
            D_DATA: begin
               if (bcnt_q == `FLTC_BYTE_BITS) begin
                  dout_d = 8'(src >> (`FLTC_BYTE_BITS - bpc));
                  tx_d   = 8'(src << bpc);
                  bcnt_d = bpc;
                  addr_d = addr_q + 32'h0000_0001;
               end else begin
                  dout_d = 8'(tx_q >> (`FLTC_BYTE_BITS - bpc));
                  tx_d   = 8'(tx_q << bpc);
                  bcnt_d = bcnt_q + bpc;
               end
            end
            D_SKIP:  state_d = D_SKIP;
            default: state_d = D_OPC;
         endcase
      end
   end

   // ---------------------------------------------------------
   // state registers
   // ---------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= D_OPC;
         cnt_q   <= 8'h00;
         op_q    <= 8'h00;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         op_q    <= op_d;
      end
   end

   // decoded command and latency counts
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         kind_q  <= FLTC_FAST;
         a4_q    <= 1'b0;
         mode_q  <= 8'h00;
         dummy_q <= 8'h00;
      end else if (beat && state_q == D_OPC && cnt_q == `FLTC_OPC_LAST) begin
         kind_q  <= kind_d;
         a4_q    <= a4_d;
         mode_q  <= mode_d;
         dummy_q <= dummy_d;
      end
   end

   // address and output shifter
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         addr_q <= 32'h0000_0000;
         tx_q   <= 8'h00;
         bcnt_q <= 4'h0;
         dout_q <= 8'h00;
      end else begin
         addr_q <= addr_d;
         tx_q   <= tx_d;
         bcnt_q <= bcnt_d;
         dout_q <= dout_d;
      end
   end

   // lane drive enable
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         oe_n_q <= 1'b1;
      end else begin
         oe_n_q <= oe_n_d;
      end
   end

   // ---------------------------------------------------------
   // outputs
   // ---------------------------------------------------------
   assign lk.d_dq_o     = dout_q;
   assign lk.d_dq_oe_n  = oe_n_q;
   assign o_rd_addr     = addr_q;
   assign o_read_active = (state_q == D_DATA);
endmodule

// ### design/fltc_host_end.sv
`timescale 1ns/1ps
`include "fltc_regs.svh"
module fltc_host_end
   import fltc_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // link to the flash
   fltc_link_if.host        lk,
   // read request
   input  wire logic        i_start,
   input  wire fltc_kind_t  i_kind,
   input  wire logic        i_addr4,
   input  wire logic [31:0] i_addr,
   input  wire logic [7:0]  i_len,
   input  wire logic [1:0]  i_latency_code,
   // read answer
   output logic             o_busy,
   output logic      [7:0]  o_byte,
   output logic             o_byte_valid,
   output logic             o_done,
   output logic             o_rate_ok
);
   typedef enum {H_IDLE, H_OPC, H_ADDR, H_MODE, H_DUMMY, H_DATA, H_END} fltc_hst_t;

   fltc_hst_t   state_q;
   logic [7:0]  div_q;
   logic        sck_q;
   logic [7:0]  cnt_q;
   logic [7:0]  op_q;
   logic [31:0] sh_q;
   logic [7:0]  dq_q;
   logic        oe_n_q;
   logic        cs_n_q;
   fltc_kind_t  kind_q;
   logic        a4_q;
   logic [7:0]  mode_q, dummy_q, len_q, nb_q;
   logic [7:0]  rx_q;
   logic [3:0]  bcnt_q;
   logic [3:0]  bpc;
   logic [7:0]  abits;
   logic [31:0] sh_nx;
   logic [7:0]  rx_nx;

   assign bpc   = fltc_bpc(kind_q);
   assign abits = a4_q ? `FLTC_ABITS4 : `FLTC_ABITS3;
   assign sh_nx = sh_q << bpc;
   assign rx_nx = 8'(rx_q << bpc) | (lk.dq & fltc_mask(bpc));

   // serial beat divider, runs only inside a frame
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_q <= 8'h00;
         sck_q <= 1'b0;
      end else if (state_q == H_IDLE || state_q == H_END) begin
         div_q <= 8'h00;
         sck_q <= 1'b0;
      end else begin
         sck_q <= (div_q == `FLTC_SCK_DIV - 8'h01);
         div_q <= (div_q == `FLTC_SCK_DIV - 8'h01) ? 8'h00 : div_q + 8'h01;
      end
   end

   // frame sequencer
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= H_IDLE;
         cnt_q <= 8'h00; op_q <= 8'h00; sh_q <= 32'h0000_0000;
         dq_q <= 8'h00; oe_n_q <= 1'b1; cs_n_q <= 1'b1;
         kind_q <= FLTC_FAST; a4_q <= 1'b0; mode_q <= 8'h00; dummy_q <= 8'h00;
         len_q <= 8'h00; nb_q <= 8'h00; rx_q <= 8'h00; bcnt_q <= 4'h0;
         o_byte <= 8'h00; o_byte_valid <= 1'b0; o_done <= 1'b0;
      end else begin
         o_byte_valid <= 1'b0;
         o_done       <= 1'b0;
         case (state_q)
            H_IDLE: if (i_start) begin
               state_q <= H_OPC;
               cnt_q   <= 8'h00;
               op_q    <= fltc_opcode(i_kind, i_addr4);
               dq_q    <= 8'(fltc_opcode(i_kind, i_addr4) >> 7);
               oe_n_q  <= 1'b0;
               cs_n_q  <= 1'b0;
               kind_q  <= i_kind;
               a4_q    <= i_addr4 & (i_kind != FLTC_QUERY);
               sh_q    <= (i_addr4 && i_kind != FLTC_QUERY) ? i_addr : (i_addr << 8);
               mode_q  <= fltc_lat(i_latency_code, i_kind, 1'b0);
               dummy_q <= fltc_lat(i_latency_code, i_kind, 1'b1);
               len_q   <= (i_len == 8'h00) ? 8'h01 : i_len;
               nb_q    <= 8'h00;
            end
            H_OPC: if (sck_q) begin
               op_q  <= op_q << 1;
               cnt_q <= cnt_q + 8'h01;
               dq_q  <= {7'h00, op_q[6]};
               if (cnt_q == `FLTC_OPC_LAST) begin
                  state_q <= H_ADDR;
                  cnt_q   <= 8'h00;
                  dq_q    <= 8'(sh_q >> (6'h20 - {2'h0, bpc}));
               end
            end
            H_ADDR: if (sck_q) begin
               sh_q  <= sh_nx;
               cnt_q <= cnt_q + {4'h0, bpc};
               dq_q  <= 8'(sh_nx >> (6'h20 - {2'h0, bpc}));
               if (cnt_q + {4'h0, bpc} == abits) begin
                  // mode cycles sit right after the address
                  cnt_q <= 8'h00;
                  if (mode_q != 8'h00) begin
                     state_q <= H_MODE;
                     dq_q    <= `FLTC_MODE_BITS;
                  end else begin
                     state_q <= H_DUMMY;
                     oe_n_q  <= 1'b1;
                  end
               end
            end
            H_MODE: if (sck_q) begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q + 8'h01 == mode_q) begin
                  state_q <= H_DUMMY;
                  cnt_q   <= 8'h00;
                  oe_n_q  <= 1'b1;
               end
            end
            H_DUMMY: if (sck_q) begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q + 8'h01 == dummy_q) begin
                  state_q <= H_DATA;
                  bcnt_q  <= 4'h0;
               end
            end
            H_DATA: if (sck_q) begin
               // data sampled only once mode and dummy are spent
               rx_q   <= rx_nx;
               bcnt_q <= bcnt_q + bpc;
               if (bcnt_q + bpc == `FLTC_BYTE_BITS) begin
                  bcnt_q       <= 4'h0;
                  o_byte       <= rx_nx;
                  o_byte_valid <= 1'b1;
                  nb_q         <= nb_q + 8'h01;
                  if (nb_q + 8'h01 == len_q) state_q <= H_END;
               end
            end
            H_END: begin
               state_q <= H_IDLE;
               cs_n_q  <= 1'b1;
               o_done  <= 1'b1;
            end
            default: state_q <= H_IDLE;
         endcase
      end
   end

   // clock rate check against the selected row's ceiling
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rate_ok <= 1'b0;
      end else begin
         o_rate_ok <= (`FLTC_SCK_MHZ <= fltc_ceiling(i_latency_code));
      end
   end

   assign lk.cs_n      = cs_n_q;
   assign lk.sck_en    = sck_q;
   assign lk.h_dq_o    = dq_q;
   assign lk.h_dq_oe_n = oe_n_q;
   assign o_busy       = (state_q != H_IDLE);
endmodule

// ### verification/fltc_link_props.sv
`timescale 1ns/1ps
module fltc_link_props
   import fltc_pkg::*;
(
   // clock and reset
   input wire logic       i_clk,
   input wire logic       i_rst_n,
   // link signals
   input wire logic       cs_n,
   input wire logic       sck_en,
   input wire logic [7:0] h_dq_o,
   input wire logic       h_dq_oe_n,
   input wire logic [7:0] d_dq_o,
   input wire logic       d_dq_oe_n,
   input wire logic [7:0] dq
);
   logic [7:0] bc_q;
   logic [7:0] op_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   // ---------------------------------------------------------
   // helper logic
   // ---------------------------------------------------------
   // beats seen in the current frame
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) bc_q <= 8'h00;
      else if (cs_n) bc_q <= 8'h00;
      else if (sck_en) bc_q <= bc_q + 8'h01;
   end

   // opcode shifted in from lane 0
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) op_q <= 8'h00;
      else if (!cs_n && sck_en && bc_q < 8'h08) op_q <= {op_q[6:0], dq[0]};
   end

   // ---------------------------------------------------------
   // properties
   // ---------------------------------------------------------
   property p_one_driver; !(!h_dq_oe_n && !d_dq_oe_n); endproperty
   property p_beat_frame; sck_en |-> !cs_n; endproperty
   property p_beat_space; sck_en |=> !sck_en; endproperty
   property p_host_first; $fell(cs_n) |-> !h_dq_oe_n; endproperty
   property p_release; $rose(cs_n) |=> d_dq_oe_n && h_dq_oe_n; endproperty
   property p_opcode;
      $rose(bc_q == 8'h08) |-> op_q inside {8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE, 8'hA7};
   endproperty
   property p_opc_lane; !cs_n && bc_q < 8'h08 |-> !h_dq_oe_n; endproperty
   property p_turn; $fell(d_dq_oe_n) |-> h_dq_oe_n && $past(h_dq_oe_n) && !cs_n; endproperty
   property p_opc_lane0; !cs_n && bc_q < 8'h08 |-> h_dq_o[7:1] == 7'h00; endproperty
   property p_lane_mux; !d_dq_oe_n && h_dq_oe_n |-> dq == d_dq_o; endproperty

   a_one_driver: assert property (p_one_driver) else $error("both ends drive lanes");
   a_beat_frame: assert property (p_beat_frame) else $error("beat outside frame");
   a_beat_space: assert property (p_beat_space) else $error("beats too close");
   a_host_first: assert property (p_host_first) else $error("host not driving");
   a_release: assert property (p_release) else $error("lanes held after frame");
   a_opcode: assert property (p_opcode) else $error("unknown read opcode");
   a_opc_lane: assert property (p_opc_lane) else $error("opcode lane released");
   a_turn: assert property (p_turn) else $error("turnaround overlap");
   a_opc_lane0: assert property (p_opc_lane0) else $error("opcode off lane 0");
   a_lane_mux: assert property (p_lane_mux) else $error("flash data not on lanes");

   // main scenarios
   c_fast: cover property ($rose(bc_q == 8'h08) && op_q == 8'h0D);
   c_quad: cover property ($rose(bc_q == 8'h08) && op_q == 8'hEE);
   c_query: cover property ($rose(bc_q == 8'h08) && op_q == 8'hA7);
   c_drive: cover property ($fell(d_dq_oe_n));
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb
   import fltc_pkg::*;
;
   typedef struct packed {
      fltc_kind_t k;
      logic a4;
      logic [1:0] lc;
      logic [7:0] ln;
      logic [31:0] ad;
      logic [7:0] eb;
      logic [7:0] eo;
   } fltc_tb_row_t;

   localparam logic [351:0] TBL = {32'h9A2A0508, 64'h46430D0EBDBEEDEE, 64'h3203040102020103,
      64'h4200040202040106, 64'h4201040402050107, 64'h4202040502060108};

   // kind, addr4, code, len, addr, beats to flash drive, opcode
   fltc_tb_row_t rows [12] = '{
      '{FLTC_FAST, 1'b0, 2'h3, 8'h03, 32'hA51234FE, 8'h19, 8'h0D},
      '{FLTC_FAST, 1'b1, 2'h0, 8'h02, 32'h7700FFFF, 8'h1E, 8'h0E},
      '{FLTC_FAST, 1'b0, 2'h1, 8'h00, 32'h00000010, 8'h1C, 8'h0D},
      '{FLTC_FAST, 1'b1, 2'h2, 8'h01, 32'h12345678, 8'h21, 8'h0E},
      '{FLTC_DUAL, 1'b0, 2'h3, 8'h04, 32'h00C0FFFE, 8'h12, 8'hBD},
      '{FLTC_DUAL, 1'b1, 2'h0, 8'h02, 32'h80000001, 8'h16, 8'hBE},
      '{FLTC_DUAL, 1'b0, 2'h1, 8'h01, 32'hFF0000AA, 8'h15, 8'hBD},
      '{FLTC_DUAL, 1'b1, 2'h2, 8'h03, 32'h0000ABCD, 8'h18, 8'hBE},
      '{FLTC_QUAD, 1'b0, 2'h3, 8'h04, 32'h335577FE, 8'h0F, 8'hED},
      '{FLTC_QUAD, 1'b1, 2'h0, 8'h02, 32'hC0DE0102, 8'h13, 8'hEE},
      '{FLTC_QUAD, 1'b0, 2'h1, 8'h01, 32'h00000003, 8'h13, 8'hED},
      '{FLTC_QUAD, 1'b1, 2'h2, 8'h02, 32'hFEDCBA98, 8'h15, 8'hEE}};

   logic        i_clk, i_rst_n, i_start, i_addr4;
   fltc_kind_t  i_kind;
   logic [31:0] i_addr, o_rd_addr;
   logic [7:0]  i_len, i_rd_byte, o_byte, nb_q, op_q, lat_q;
   logic [1:0]  i_lc;
   logic        o_busy, o_byte_valid, o_done, o_rate_ok, o_read_active, oe_q, cs_q;
   int          err_total, checks, nfr_q, cyc;

   fltc_link_if lk ();
   fltc_host_end i_fltc_host_end (.i_clk(i_clk), .i_rst_n(i_rst_n), .lk(lk.host),
      .i_start(i_start), .i_kind(i_kind), .i_addr4(i_addr4), .i_addr(i_addr), .i_len(i_len),
      .i_latency_code(i_lc), .o_busy(o_busy), .o_byte(o_byte), .o_byte_valid(o_byte_valid),
      .o_done(o_done), .o_rate_ok(o_rate_ok));
   fltc_flash_end i_fltc_flash_end (.i_clk(i_clk), .i_rst_n(i_rst_n), .lk(lk.dev),
      .i_latency_code(i_lc), .o_rd_addr(o_rd_addr), .i_rd_byte(i_rd_byte),
      .o_read_active(o_read_active));
   fltc_link_props i_fltc_link_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .cs_n(lk.cs_n),
      .sck_en(lk.sck_en), .h_dq_o(lk.h_dq_o), .h_dq_oe_n(lk.h_dq_oe_n), .d_dq_o(lk.d_dq_o),
      .d_dq_oe_n(lk.d_dq_oe_n), .dq(lk.dq));

   // ---------------------------------------------------------
   // array contents and link watch
   // ---------------------------------------------------------
   function automatic logic [7:0] mem(input logic [31:0] a);
      mem = a[7:0] ^ a[15:8] ^ a[31:24] ^ 8'h3C;
   endfunction

   function automatic logic [7:0] tbl_byte(input logic [5:0] o);
      tbl_byte = (o > 6'h2B) ? 8'hFF : TBL[351 - 8 * o -: 8];
   endfunction

   assign i_rd_byte = mem(o_rd_addr);
   always #25 i_clk = ~i_clk;

   // beat count, opcode, beats before the flash drives, frame count
   always @(posedge i_clk) begin
      if (lk.cs_n === 1'b1) nb_q <= 8'h00;
      else if (lk.sck_en === 1'b1) begin
         nb_q <= nb_q + 8'h01;
         if (nb_q < 8'h08) op_q <= {op_q[6:0], lk.dq[0]};
      end
      if (lk.d_dq_oe_n === 1'b0 && oe_q === 1'b1) lat_q <= nb_q;
      if (lk.cs_n === 1'b0 && cs_q === 1'b1) nfr_q <= nfr_q + 1;
      oe_q <= lk.d_dq_oe_n;
      cs_q <= lk.cs_n;
   end

   // hang guard
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         err_total = err_total + 1;
         test_done;
      end
   end

   // ---------------------------------------------------------
   // tasks
   // ---------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic test_done;
      if (err_total == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic run(input fltc_tb_row_t r, input bit poke);
      int n, f, t;
      logic [31:0] a;
      logic [7:0] e;
      n = 0;
      @(posedge i_clk);
      #1;
      f = nfr_q;
      i_kind = r.k;
      {i_addr4, i_lc, i_len, i_addr} = {r.a4, r.lc, r.ln, r.ad};
      i_start = 1'b1;
      for (t = 0; t < 2000; t++) begin
         @(posedge i_clk);
         #1;
         i_start = poke && t == 30;
         if (i_start) chk("busy", 32'h1, 32'(o_busy));
         if (o_byte_valid === 1'b1) begin
            a = r.a4 ? r.ad + n : {8'h00, r.ad[23:0] + 24'(n)};
            e = (r.k == FLTC_QUERY) ? tbl_byte(r.ad[5:0] + 6'(n)) : mem(a);
            chk("byte", 32'(e), 32'(o_byte));
            chk("read_active", 32'h1, 32'(o_read_active));
            n++;
         end
         if (o_done === 1'b1) break;
      end
      chk("done", 32'h1, 32'(o_done));
      chk("count", (r.ln == 8'h00) ? 32'h1 : 32'(r.ln), 32'(n));
      chk("opcode", 32'(r.eo), 32'(op_q));
      chk("latency", 32'(r.eb), 32'(lat_q));
      chk("frames", 32'(f + 1), 32'(nfr_q));
      chk("rate_ok", 32'h1, 32'(o_rate_ok));
   endtask

   // ---------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------
   initial begin
      {i_clk, i_rst_n, i_start, i_addr4, i_addr, i_len, i_lc} = '0;
      i_kind = FLTC_FAST;
      {err_total, checks, nfr_q, cyc} = '0;
      repeat (8) @(posedge i_clk);
      #1 i_rst_n = 1'b1;
      foreach (rows[i]) run(rows[i], 1'b0);
      // whole table, one byte past its end
      run('{FLTC_QUERY, 1'b0, 2'h1, 8'h2D, 32'h0, 8'h15, 8'hA7}, 1'b0);
      // second start inside a frame is ignored
      run('{FLTC_FAST, 1'b1, 2'h2, 8'h02, 32'h01020304, 8'h21, 8'h0E}, 1'b1);
      // reset in mid-frame, then recover
      @(posedge i_clk);
      #1 i_start = 1'b1;
      @(posedge i_clk);
      #1 i_start = 1'b0;
      repeat (20) @(posedge i_clk);
      #1;
      chk("busy", 32'h1, 32'(o_busy));
      i_rst_n = 1'b0;
      #1;
      chk("cs_n", 32'h1, 32'(lk.cs_n));
      chk("oe_n", 32'h3, 32'({lk.h_dq_oe_n, lk.d_dq_oe_n}));
      chk("busy", 32'h0, 32'(o_busy));
      chk("read_active", 32'h0, 32'(o_read_active));
      @(posedge i_clk);
      #1 i_rst_n = 1'b1;
      run(rows[8], 1'b0);
      test_done;
   end
endmodule
